// File: hdl/pio_pkg.sv
package pio_pkg;

    // bus geometry: each register index takes one aligned 32-bit word
    localparam int PIO_ADDR_W = 6;
    localparam int PIO_IDX_W = 4;
    localparam int PIO_NPORT = 5;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_PORT_A_DATA = 4'h0;
    localparam logic [3:0] IDX_PORT_B_DATA = 4'h1;
    localparam logic [3:0] IDX_PORT_C_DATA = 4'h2;
    localparam logic [3:0] IDX_PORT_D_LEVELS = 4'h3;
    localparam logic [3:0] IDX_PORT_A_DIR = 4'h4;
    localparam logic [3:0] IDX_PORT_B_DIR = 4'h5;
    localparam logic [3:0] IDX_PORT_C_DIR = 4'h6;
    localparam logic [3:0] IDX_HOLE_0 = 4'h7;
    localparam logic [3:0] IDX_PORT_E_DATA = 4'h8;
    localparam logic [3:0] IDX_PORT_F_DATA = 4'h9;
    localparam logic [3:0] IDX_HOLE_1 = 4'hA;
    localparam logic [3:0] IDX_HOLE_2 = 4'hB;
    localparam logic [3:0] IDX_PORT_E_DIR = 4'hC;
    localparam logic [3:0] IDX_PORT_F_DIR = 4'hD;
    localparam logic [3:0] IDX_LAST = 4'hD;

    // per-port tables, slot order A, B, C, E, F (slot 0 is port A)
    localparam logic [4:0][3:0] PIO_DATA_IDX = {IDX_PORT_F_DATA, IDX_PORT_E_DATA,
        IDX_PORT_C_DATA, IDX_PORT_B_DATA, IDX_PORT_A_DATA};
    localparam logic [4:0][3:0] PIO_DIR_IDX = {IDX_PORT_F_DIR, IDX_PORT_E_DIR,
        IDX_PORT_C_DIR, IDX_PORT_B_DIR, IDX_PORT_A_DIR};
    localparam logic [4:0][7:0] PIO_MASK = {8'h3F, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
    localparam logic [7:0] PIO_D_MASK = 8'h7F;
    localparam logic [7:0] PIO_DIR_RESET = 8'h00;

    // bus responses
    localparam logic [1:0] PIO_RESP_OKAY = 2'b00;
    localparam logic [1:0] PIO_RESP_SLVERR = 2'b10;

    // the 37 two-way pins, one field per port at its real width
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [6:0] c;
        logic [7:0] e;
        logic [5:0] f;
    } pio_pins_s;

endpackage : pio_pkg

// File: hdl/pio_ports.sv
`timescale 1ns/10ps
// Overview of operation
// RULE1 - six ports: thirty-seven two-way pins plus seven input-only pins
// RULE2 - port A is eight bits, one latch and one direction bit per pin
// RULE3 - port A latches are read/write, untouched by reset, undefined at power-up
// RULE4 - direction 1 drives the latched value, 0 leaves the pin floating
// RULE5 - reset clears all port A direction bits, every pin an input
// RULE6 - output pins read back their latch value at the data address
// RULE7 - input pins read back the level present on the pin
// RULE8 - data writes always reach the latch, whatever the direction
// RULE9 - software should load the latch before turning a pin to output
// RULE10 - data latches at A 0, B 1, C 2, E 8, F 9, reset-proof
// RULE11 - direction registers at A 4, B 5, C 6, E C, F D, reset to 0
// RULE12 - port D at 3: seven input bits, bit 7 reads 0, writes ignored
// RULE13 - port C data and direction implement bits 6..0, bit 7 reads 0
// RULE14 - port F data and direction implement bits 5..0, bits 7..6 read 0
// RULE15 - small package: software sets C1, E0-E2, F0-F3 as outputs
// RULE16 - holes at 7, A and B ignore writes and read zero
module pio_ports
    import pio_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // axi4-lite write address and data
    input wire logic [PIO_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [PIO_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // two-way pins of ports A, B, C, E, F; 37 two-way plus 7 input pins (see RULE1)
    input wire pio_pins_s pin_in,
    output pio_pins_s pin_out,
    output pio_pins_s pin_oe_n,
    // input-only port D
    input wire logic [6:0] port_d_in
);

    // write channel state
    logic aw_held_q;
    logic [PIO_ADDR_W-1:0] awaddr_q;
    logic w_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    // read channel state
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    // per-port storage, slot order A, B, C, E, F
    logic [7:0] latch_q [PIO_NPORT];
    logic [7:0] dir_q [PIO_NPORT];
    logic [4:0][7:0] pin_lvl;
    logic [4:0][7:0] rd_view;
    logic [4:0][7:0] lat_vec;
    logic [4:0][7:0] dir_vec;
    logic [7:0] rd_mux;

    // handshake decode; one write in flight, response must drain first
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_held_q || aw_take;
    wire have_w = w_held_q || w_take;
    wire wr_fire = have_aw && have_w && !bvalid_q;
    wire [PIO_ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
    wire [PIO_IDX_W-1:0] wr_idx = wr_addr[PIO_ADDR_W-1:2];
    wire wr_in_range = wr_idx <= IDX_LAST;
    // only lane 0 carries register bits; a write without it changes nothing
    wire wr_en = wr_fire && wr_in_range && wr_strb[0];
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [PIO_IDX_W-1:0] rd_idx = s_axi_araddr[PIO_ADDR_W-1:2];
    wire rd_in_range = rd_idx <= IDX_LAST;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // pin struct to slot vectors and back
    assign pin_lvl = {{2'b00, pin_in.f}, pin_in.e, {1'b0, pin_in.c}, pin_in.b, pin_in.a};
    assign pin_out = {lat_vec[0], lat_vec[1], lat_vec[2][6:0], lat_vec[3], lat_vec[4][5:0]};
    // oe_n low while driving: direction 1 enables the buffer (see RULE4)
    assign pin_oe_n = ~{dir_vec[0], dir_vec[1], dir_vec[2][6:0], dir_vec[3], dir_vec[4][5:0]};

    // address and data capture; aw and w may arrive in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            aw_held_q <= have_aw && !wr_fire;
            w_held_q <= have_w && !wr_fire;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // write response; holes answer okay, beyond the map is an error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= PIO_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_in_range ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // one generate slot per two-way port; slot 0 is the eight-bit port A (see RULE2)
    for (genvar p = 0; p < PIO_NPORT; p++) begin : g_port
        wire hit_data = wr_en && (wr_idx == PIO_DATA_IDX[p]);
        wire hit_dir = wr_en && (wr_idx == PIO_DIR_IDX[p]);

        // latch has no reset on purpose: it keeps its value through reset
        always_ff @(posedge clk) begin
            if (hit_data) begin
                latch_q[p] <= wr_data[7:0] & PIO_MASK[p]; // see RULE8 see RULE3
            end
        end

        // direction clears on reset, every pin an input
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                dir_q[p] <= PIO_DIR_RESET; // see RULE5 see RULE11
            end else if (hit_dir) begin
                dir_q[p] <= wr_data[7:0] & PIO_MASK[p]; // see RULE13 see RULE14
            end
        end

        assign lat_vec[p] = latch_q[p];
        assign dir_vec[p] = dir_q[p];
        // outputs read their latch, inputs read the pin (see RULE6 see RULE7)
        assign rd_view[p] = ((dir_q[p] & latch_q[p]) | (~dir_q[p] & pin_lvl[p])) & PIO_MASK[p];
    end

    // read decode; holes and unused bits read zero (see RULE16 see RULE10)
    always_comb begin
        if (rd_idx == IDX_PORT_A_DATA) begin
            rd_mux = rd_view[0];
        end else if (rd_idx == IDX_PORT_B_DATA) begin
            rd_mux = rd_view[1];
        end else if (rd_idx == IDX_PORT_C_DATA) begin
            rd_mux = rd_view[2];
        end else if (rd_idx == IDX_PORT_D_LEVELS) begin
            rd_mux = {1'b0, port_d_in} & PIO_D_MASK; // see RULE12
        end else if (rd_idx == IDX_PORT_A_DIR) begin
            rd_mux = dir_q[0];
        end else if (rd_idx == IDX_PORT_B_DIR) begin
            rd_mux = dir_q[1];
        end else if (rd_idx == IDX_PORT_C_DIR) begin
            rd_mux = dir_q[2];
        end else if (rd_idx == IDX_PORT_E_DATA) begin
            rd_mux = rd_view[3];
        end else if (rd_idx == IDX_PORT_F_DATA) begin
            rd_mux = rd_view[4];
        end else if (rd_idx == IDX_PORT_E_DIR) begin
            rd_mux = dir_q[3];
        end else if (rd_idx == IDX_PORT_F_DIR) begin
            rd_mux = dir_q[4];
        end else begin
            rd_mux = 8'h00;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= PIO_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_mux};
            rresp_q <= rd_in_range ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : pio_ports

// File: tb/pio_pins_model.sv
`timescale 1ns/10ps
module pio_pins_model
    import pio_pkg::*;
(
    // board levels and pad drive
    input wire pio_pins_s ext,
    input wire pio_pins_s drv,
    input wire pio_pins_s oe_n,
    output pio_pins_s lvl
);
    // driven pins follow the pad, floating ones the board level
    assign lvl = (drv & ~oe_n) | (ext & oe_n);
endmodule : pio_pins_model

// File: tb/pio_checker.sv
`timescale 1ns/10ps
module pio_checker
    import pio_pkg::*;
(
    // bus handshakes and pad enables
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pio_pins_s pin_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // write address and data taken together
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_wr_answer: assert property (s_wr |=> s_axi_bvalid)
        else $error("write not answered");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_oe_reset: assert property ($fell(rst) |-> pin_oe_n == '1)
        else $error("pin driven after reset");
    a_oe_by_write: assert property (!$stable(pin_oe_n) |->
        s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("enable moved without write");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
endmodule : pio_checker

bind pio_ports pio_checker u_pio_checker (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_oe_n);

// File: tb/parallel_io_ports_tb_top.sv
`timescale 1ns/10ps
module parallel_io_ports_tb_top;
    import pio_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic [5:0] awaddr = 0;
    logic [5:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    pio_pins_s ext = {8'h3C, 29'h0};
    pio_pins_s pin_in, pout, oe;
    logic [6:0] dpin = 7'h55;
    int bad_count = 0;
    int samples_checked = 0;

    always #4 clk = ~clk;

    pio_ports u_pio_ports (.clk, .rst, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pout), .pin_oe_n(oe),
        .port_d_in(dpin));
    pio_pins_model u_pio_pins_model (.ext(ext), .drv(pout), .oe_n(oe), .lvl(pin_in));

    task finish_test;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    task chk(input logic [36:0] got, input logic [36:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic seen(int k);
        case (k)
            0: return awready & wready;
            1: return bvalid;
            2: return arready;
            default: return rvalid;
        endcase
    endfunction : seen

    // bounded wait for one handshake edge; ready is looked at mid-cycle, where it
    // already holds the value that the next rising edge will sample
    task hs(input int k);
        int n;
        n = 0;
        @(negedge clk);
        while (seen(k) !== 1'b1 && n < 64) begin
            @(negedge clk);
            n++;
        end
        if (n >= 64) begin
            bad_count++;
            finish_test();
        end
        @(posedge clk);
    endtask : hs

    // answers are accepted a cycle late to exercise the held response
    task wr(input logic [3:0] i, input logic [7:0] d);
        awaddr <= {i, 2'b00};
        wdata <= {24'h00_0000, d};
        awv <= 1;
        wv <= 1;
        hs(0);
        awv <= 0;
        wv <= 0;
        @(posedge clk);
        bready <= 1;
        hs(1);
        bready <= 0;
        chk(37'(bresp), 37'(i > IDX_LAST ? PIO_RESP_SLVERR : PIO_RESP_OKAY));
    endtask : wr

    task rdc(input logic [3:0] i, input logic [7:0] e);
        araddr <= {i, 2'b00};
        arv <= 1;
        hs(2);
        arv <= 0;
        @(posedge clk);
        rready <= 1;
        hs(3);
        rready <= 0;
        chk(37'(rdata), 37'(e));
        chk(37'(rresp), 37'(i > IDX_LAST ? PIO_RESP_SLVERR : PIO_RESP_OKAY));
    endtask : rdc

    task t_reset;
        chk(oe, {37{1'b1}});
        for (int k = 0; k < PIO_NPORT; k++)
            rdc(PIO_DIR_IDX[k], PIO_DIR_RESET);
    endtask : t_reset

    task t_port_a;
        wr(IDX_PORT_A_DATA, 8'hA5);
        rdc(IDX_PORT_A_DATA, 8'h3C);
        wr(IDX_PORT_A_DIR, 8'hF0);
        rdc(IDX_PORT_A_DATA, 8'hAC);
        chk(37'(oe.a), 37'h0F);
        chk(37'(pout.a[7:4]), 37'hA);
    endtask : t_port_a

    task t_keep;
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        chk(37'(oe.a), 37'hFF);
        wr(IDX_PORT_A_DIR, 8'hFF);
        rdc(IDX_PORT_A_DATA, 8'hA5);
    endtask : t_keep

    task t_map;
        logic [13:0][7:0] e;
        e = 112'h3FFF_0000_3FFF_007F_FFFF_557F_FFFF;
        for (int k = 0; k <= 13; k++)
            wr(4'(k), 8'hFF);
        for (int k = 0; k <= 13; k++)
            rdc(4'(k), e[k]);
        chk(oe, 37'h0);
        chk(pout, {8'hFF, 8'hFF, 7'h7F, 8'hFF, 6'h3F});
        wr(4'hE, 8'hFF);
        rdc(4'hE, 8'h00);
    endtask : t_map

    // small package set-up: only the listed pins become outputs
    task t_small;
        wr(IDX_PORT_C_DIR, 8'h02);
        wr(IDX_PORT_E_DIR, 8'h07);
        wr(IDX_PORT_F_DIR, 8'h0F);
        chk(37'(oe.c), 37'h7D);
        chk(37'(oe.e), 37'hF8);
        chk(37'(oe.f), 37'h30);
    endtask : t_small

    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        t_reset();
        t_port_a();
        t_keep();
        t_map();
        t_small();
        finish_test();
    end
endmodule : parallel_io_ports_tb_top
